// ===== include/mtp_pkg.sv
// shared types and constants for the memory-type cache policy block
`default_nettype none
package mtp_pkg;

  // widths of the type and access-kind codes
  localparam int TYPE_W = 3;
  localparam int KIND_W = 2;

  // reset level of every control flop and decision output
  localparam logic RST_LEVEL = 1'b0;

  // memory types; code 3'h3 is unused and treated as uncacheable
  typedef enum logic [TYPE_W-1:0] {
    uncacheable_type            = 3'h0,
    write_combining_type        = 3'h1,
    combining_plus_snooped_type = 3'h2,
    writethrough_type           = 3'h4,
    write_protect_type          = 3'h5,
    writeback_type              = 3'h6,
    cache_disabled_type         = 3'h7
  } mem_type_e;

  // kind of access offered by the core pipeline
  typedef enum logic [KIND_W-1:0] {
    kind_load  = 2'h0,
    kind_store = 2'h1,
    kind_fetch = 2'h2
  } access_kind_e;

  // handling decided for one access
  typedef struct packed {
    logic cache_read;        // served from or filled into a cache
    logic allocate;          // allocate a line
    logic update_line;       // write data into the cached line
    logic set_modified;      // line goes to modified state
    logic drop_line;         // invalidate the hit data line
    logic icache_inv;        // invalidate the hit instruction line
    logic no_icache_replace; // fetch miss must not replace a line
    logic mem_read;          // read main memory
    logic mem_write;         // write main memory
    logic combine;           // route via write-combining buffers
    logic use_wbuf;          // may be held in the write buffer
    logic snoop_all;         // snoop every processor, self included
    logic in_order;          // strictly ordered, no bypass
  } policy_s;

endpackage
`default_nettype wire

// ===== include/mem_type_if.sv
// type resolution signals between the policy top and its resolver
`default_nettype none
interface mem_type_if;
  mtp_pkg::mem_type_e page_type;  // type from page attribute table
  mtp_pkg::mem_type_e range_type; // type from range type registers
  logic               cd_bit;     // cache_disable_control_bit
  logic               inv_pulse;  // either invalidate instruction done
  mtp_pkg::mem_type_e eff_type;   // resolved effective type
  logic               cd_stale;   // caches disabled, not invalidated

  modport resolver (
    input  page_type,
    input  range_type,
    input  cd_bit,
    input  inv_pulse,
    output eff_type,
    output cd_stale
  );

  modport user (
    output page_type,
    output range_type,
    output cd_bit,
    output inv_pulse,
    input  eff_type,
    input  cd_stale
  );
endinterface
`default_nettype wire

// ===== hdl/mem_type_resolver.sv
// effective memory type resolution with cache-disabled inference
`default_nettype none
module mem_type_resolver (
  input wire logic    i_clk_sys,
  input wire logic    i_rst,
  mem_type_if.resolver tif
);

  logic inv_since_disable; // caches emptied while disabled

  // types that would normally live in the caches
  function automatic logic is_cacheable(input mtp_pkg::mem_type_e t);
    return (t == mtp_pkg::write_protect_type) ||
           (t == mtp_pkg::writethrough_type) ||
           (t == mtp_pkg::writeback_type);
  endfunction

  // sticky invalidate marker; an invalidate sets it only while the control bit is high
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      inv_since_disable <= mtp_pkg::RST_LEVEL;
    end else if (tif.inv_pulse && tif.cd_bit) begin
      inv_since_disable <= 1'b1;
    end else if (!tif.cd_bit) begin
      // re-enabling arms the check for the next disable
      inv_since_disable <= 1'b0;
    end
  end

  // conflict first, then the disable state of the caches
  always_comb begin
    tif.cd_stale = tif.cd_bit && !inv_since_disable;
    if (tif.page_type != tif.range_type) begin
      tif.eff_type = mtp_pkg::cache_disabled_type;
    end else if (tif.cd_bit && is_cacheable(tif.page_type)) begin
      // once emptied nothing can hit, so plain uncacheable is safe
      tif.eff_type = inv_since_disable ? mtp_pkg::uncacheable_type
                                       : mtp_pkg::cache_disabled_type;
    end else begin
      tif.eff_type = tif.page_type;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  chk_stale_infers_cd: assert property (
    (tif.cd_stale && tif.page_type == tif.range_type &&
     is_cacheable(tif.page_type)) |->
      tif.eff_type == mtp_pkg::cache_disabled_type
  ) else $error("stale disabled caches did not infer cd type");

endmodule
`default_nettype wire

// ===== hdl/memory_type_cache_policy.sv
// per-access caching, buffering and ordering policy by memory type
`default_nettype none
// Behaviour
// - uncacheable: no caching, speculation or combining
// - drain write buffers before uncacheable access
// - disabled, uninvalidated caches make cacheable become cd
// - page/range type conflict infers cache-disabled type
// - cd data hit: writeback if modified, invalidate, continue
// - cd fetch: hit from icache, miss no replace
// - cd write hitting icache invalidates icache line
// - write-combining: uncached, speculative reads, writes merged
// - combining-plus: combine and snoop all caches
// - write-protect reads cached, allocate, may speculate
// - write-protect writes memory, hit invalidates line
// - writethrough writes memory, hit updates, keeps state
// - writethrough write miss no allocate; reads allocate
// - writeback reads allocate, may speculate
// - writeback write hit updates line, sets modified
// - writeback write miss allocates modified line
// - writeback writes memory only on writeback
// - combining buffers separate from write buffers
// - uncacheable/combining writes always update memory
module memory_type_cache_policy (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_rst,
  input  wire logic                  i_req_valid,
  input  wire mtp_pkg::access_kind_e i_req_kind,
  input  wire logic                  i_req_spec,
  input  wire mtp_pkg::mem_type_e    i_page_type,
  input  wire mtp_pkg::mem_type_e    i_range_type,
  input  wire logic                  i_cache_disable_control_bit,
  input  wire logic                  i_invalidate_done,
  input  wire logic                  i_data_hit,
  input  wire logic                  i_line_modified,
  input  wire logic                  i_icache_hit,
  input  wire logic                  i_wbuf_empty,
  input  wire logic                  i_mem_idle,
  input  wire logic                  i_cache_ack,
  output logic                       o_req_ready,
  output logic                       o_reject,
  output logic                       o_issue,
  output mtp_pkg::mem_type_e         o_eff_type,
  output logic                       o_cache_read,
  output logic                       o_allocate,
  output logic                       o_update_line,
  output logic                       o_set_modified,
  output logic                       o_drop_line,
  output logic                       o_icache_inv,
  output logic                       o_no_icache_replace,
  output logic                       o_mem_read,
  output logic                       o_mem_write,
  output logic                       o_combine,
  output logic                       o_use_wbuf,
  output logic                       o_snoop_all,
  output logic                       o_in_order,
  output logic                       o_drain_wbuf,
  output logic                       o_line_writeback,
  output logic                       o_line_invalidate,
  output logic                       o_cd_stale
);

  // sequencing of strictly ordered accesses
  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_drain = 2'b01,
    st_flush = 2'b10,
    st_inval = 2'b11
  } state_e;

  state_e                state;      // current step
  state_e                next_state; // step after this edge
  mtp_pkg::access_kind_e req_kind;   // held access kind
  mtp_pkg::mem_type_e    req_type;   // held effective type
  logic                  req_hit;    // held data cache hit
  logic                  req_mod;    // held modified state of hit
  logic                  req_ihit;   // held instruction cache hit
  mtp_pkg::policy_s      pol;        // registered decision
  mtp_pkg::policy_s      next_pol;   // decision being issued
  mtp_pkg::mem_type_e    cur_type;   // type seen by the decoder
  logic                  take;       // request accepted this edge
  logic                  refuse;     // accepted request is refused
  logic                  go_issue;   // decision goes out this edge
  logic                  issue_hit;  // hit seen by the decoder

  mem_type_if tif ();

  // resolver inputs come straight from the request side
  assign tif.page_type  = i_page_type;
  assign tif.range_type = i_range_type;
  assign tif.cd_bit     = i_cache_disable_control_bit;
  assign tif.inv_pulse  = i_invalidate_done;

  mem_type_resolver u_resolver (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .tif       (tif)
  );

  // strictly ordered types go through the drain sequence
  function automatic logic is_ordered(input mtp_pkg::mem_type_e t);
    return (t == mtp_pkg::cache_disabled_type) ||
           (t == mtp_pkg::uncacheable_type) ||
           !(t inside {mtp_pkg::write_combining_type,
                       mtp_pkg::combining_plus_snooped_type,
                       mtp_pkg::writethrough_type,
                       mtp_pkg::write_protect_type,
                       mtp_pkg::writeback_type});
  endfunction

  // per-type decision table for one access
  function automatic mtp_pkg::policy_s decide(
    input mtp_pkg::mem_type_e    t,
    input mtp_pkg::access_kind_e k,
    input logic                  dhit,
    input logic                  ihit
  );
    mtp_pkg::policy_s p;
    logic             st;
    logic             fe;
    logic             h;
    p  = '0;
    st = (k == mtp_pkg::kind_store);
    fe = (k == mtp_pkg::kind_fetch);
    h  = fe ? ihit : dhit;
    unique case (t)
      mtp_pkg::cache_disabled_type: begin
        p.in_order          = 1'b1;
        p.cache_read        = fe && ihit;
        p.mem_read          = !st && !(fe && ihit);
        p.no_icache_replace = fe;
        p.mem_write         = st;
        p.icache_inv        = st && ihit;
      end
      mtp_pkg::write_combining_type: begin
        // merged writes may leave out of program order
        p.mem_read  = !st;
        p.mem_write = st;
        p.combine   = st;
      end
      mtp_pkg::combining_plus_snooped_type: begin
        p.mem_read  = !st;
        p.mem_write = st;
        p.combine   = st;
        p.snoop_all = 1'b1;
      end
      mtp_pkg::write_protect_type: begin
        if (st) begin
          p.mem_write = 1'b1;
          p.use_wbuf  = 1'b1;
          p.drop_line = h;
        end else begin
          p.cache_read = 1'b1;
          p.allocate   = !h;
          p.mem_read   = !h;
        end
      end
      mtp_pkg::writethrough_type: begin
        if (st) begin
          // state bits untouched: set_modified stays low
          p.mem_write   = 1'b1;
          p.use_wbuf    = 1'b1;
          p.update_line = h;
        end else begin
          p.cache_read = 1'b1;
          p.allocate   = !h;
          p.mem_read   = !h;
        end
      end
      mtp_pkg::writeback_type: begin
        if (st) begin
          // memory sees this data only when the line is written back
          p.update_line  = 1'b1;
          p.allocate     = !h;
          p.set_modified = 1'b1;
          p.use_wbuf     = 1'b1;
        end else begin
          // fill state (shared, exclusive) is chosen by the cache
          p.cache_read = 1'b1;
          p.allocate   = !h;
          p.mem_read   = !h;
        end
      end
      default: begin
        // uncacheable and the unused code: nothing cached or merged
        p.in_order  = 1'b1;
        p.mem_read  = !st;
        p.mem_write = st;
      end
    endcase
    return p;
  endfunction

  // acceptance, refusal and the next step
  always_comb begin
    take       = i_req_valid && o_req_ready;
    cur_type   = (state == st_idle) ? tif.eff_type : req_type;
    // speculative writes never, speculative ordered reads never
    refuse     = i_req_spec && ((i_req_kind == mtp_pkg::kind_store) ||
                                is_ordered(tif.eff_type));
    go_issue   = 1'b0;
    issue_hit  = (state == st_idle) ? i_data_hit : req_hit;
    next_state = state;
    unique case (state)
      st_idle: begin
        if (take && !refuse) begin
          if (is_ordered(tif.eff_type)) begin
            next_state = st_drain;
          end else begin
            go_issue = 1'b1;
          end
        end
      end
      st_drain: begin
        // buffers empty and earlier accesses done: no passing
        if (i_wbuf_empty && i_mem_idle) begin
          if (req_type == mtp_pkg::cache_disabled_type &&
              req_kind != mtp_pkg::kind_fetch && req_hit) begin
            next_state = req_mod ? st_flush : st_inval;
          end else begin
            next_state = st_idle;
            go_issue   = 1'b1;
          end
        end
      end
      st_flush: begin
        if (i_cache_ack) begin
          next_state = st_inval;
        end
      end
      st_inval: begin
        // after the invalidate the access runs as a miss
        issue_hit = 1'b0;
        if (i_cache_ack) begin
          next_state = st_idle;
          go_issue   = 1'b1;
        end
      end
    endcase
    next_pol = decide(cur_type,
                      (state == st_idle) ? i_req_kind : req_kind,
                      issue_hit,
                      (state == st_idle) ? i_icache_hit : req_ihit);
  end

  // sequence state
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state <= st_idle;
    end else begin
      state <= next_state;
    end
  end

  // request capture; lookups are held for the whole sequence
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      req_kind <= mtp_pkg::kind_load;
      req_type <= mtp_pkg::uncacheable_type;
      req_hit  <= mtp_pkg::RST_LEVEL;
      req_mod  <= mtp_pkg::RST_LEVEL;
      req_ihit <= mtp_pkg::RST_LEVEL;
    end else if (take) begin
      req_kind <= i_req_kind;
      req_type <= tif.eff_type;
      req_hit  <= i_data_hit;
      req_mod  <= i_line_modified;
      req_ihit <= i_icache_hit;
    end
  end

  // handshake and cache-action outputs
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_req_ready       <= mtp_pkg::RST_LEVEL;
      o_reject          <= mtp_pkg::RST_LEVEL;
      o_drain_wbuf      <= mtp_pkg::RST_LEVEL;
      o_line_writeback  <= mtp_pkg::RST_LEVEL;
      o_line_invalidate <= mtp_pkg::RST_LEVEL;
      o_cd_stale        <= mtp_pkg::RST_LEVEL;
    end else begin
      // ready mirrors the idle step, one request in flight at most
      o_req_ready       <= (next_state == st_idle);
      o_reject          <= take && refuse;
      o_drain_wbuf      <= (next_state == st_drain);
      o_line_writeback  <= (next_state == st_flush);
      o_line_invalidate <= (next_state == st_inval);
      o_cd_stale        <= tif.cd_stale;
    end
  end

  // decision outputs, valid in the o_issue cycle only
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_issue    <= mtp_pkg::RST_LEVEL;
      o_eff_type <= mtp_pkg::uncacheable_type;
      pol        <= '0;
    end else begin
      o_issue    <= go_issue;
      o_eff_type <= (state == st_idle) ? tif.eff_type : req_type;
      pol        <= go_issue ? next_pol : '0;
    end
  end

  assign o_cache_read        = pol.cache_read;
  assign o_allocate          = pol.allocate;
  assign o_update_line       = pol.update_line;
  assign o_set_modified      = pol.set_modified;
  assign o_drop_line         = pol.drop_line;
  assign o_icache_inv        = pol.icache_inv;
  assign o_no_icache_replace = pol.no_icache_replace;
  assign o_mem_read          = pol.mem_read;
  assign o_mem_write         = pol.mem_write;
  assign o_combine           = pol.combine;
  assign o_use_wbuf          = pol.use_wbuf;
  assign o_snoop_all         = pol.snoop_all;
  assign o_in_order          = pol.in_order;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  // an ordered request accepted without refusal
  sequence seq_ordered_take;
    take && !refuse && is_ordered(tif.eff_type);
  endsequence

  // a modified cd line acknowledged after writeback
  sequence seq_flush_done;
    state == st_flush && i_cache_ack;
  endsequence

  chk_uc_never_cached: assert property (
    o_issue && o_eff_type == mtp_pkg::uncacheable_type |->
      !o_cache_read && !o_allocate && !o_combine && !o_use_wbuf
  ) else $error("uncacheable access cached, merged or buffered");

  chk_drain_before_uc: assert property (
    seq_ordered_take |=> o_drain_wbuf && !o_issue
  ) else $error("ordered access skipped the write buffer drain");

  chk_ordered_issue_idle: assert property (
    o_issue && o_in_order && !$past(o_line_invalidate) |->
      $past(i_wbuf_empty) && $past(i_mem_idle)
  ) else $error("ordered access issued before earlier work done");

  chk_conflict_gives_cd: assert property (
    take && i_page_type != i_range_type |=>
      req_type == mtp_pkg::cache_disabled_type
  ) else $error("type conflict did not infer cd type");

  chk_cd_flush_order: assert property (
    seq_flush_done |=> o_line_invalidate && !o_line_writeback ##1
      !o_issue [*1]
  ) else $error("cd modified line not invalidated after writeback");

  chk_cd_fetch_serve: assert property (
    o_issue && o_eff_type == mtp_pkg::cache_disabled_type &&
    o_no_icache_replace |->
      !o_allocate && (o_cache_read != o_mem_read)
  ) else $error("cd fetch replaced a line or chose no source");

  chk_cd_icache_inval: assert property (
    o_issue && o_eff_type == mtp_pkg::cache_disabled_type &&
    o_mem_write |-> o_icache_inv == req_ihit
  ) else $error("cd write hit left instruction line valid");

  chk_combine_split: assert property (
    o_issue && o_combine |->
      !o_use_wbuf && !o_cache_read && o_mem_write &&
      o_eff_type inside {mtp_pkg::write_combining_type,
                         mtp_pkg::combining_plus_snooped_type}
  ) else $error("combining write cached or put in write buffer");

  chk_plus_snoops: assert property (
    o_issue && o_eff_type == mtp_pkg::combining_plus_snooped_type |->
      o_snoop_all
  ) else $error("combining-plus access did not snoop");

  chk_wp_write_drop: assert property (
    o_issue && o_eff_type == mtp_pkg::write_protect_type &&
    o_mem_write |-> !o_update_line && o_drop_line == req_hit
  ) else $error("write-protect write updated or kept hit line");

  chk_wb_write_local: assert property (
    o_issue && o_eff_type == mtp_pkg::writeback_type &&
    o_set_modified |-> o_update_line && !o_mem_write &&
      o_allocate == !req_hit
  ) else $error("writeback write went to memory or missed allocate");

  chk_spec_write_refused: assert property (
    take && i_req_spec && i_req_kind == mtp_pkg::kind_store |=>
      o_reject && !o_issue && !o_drain_wbuf
  ) else $error("speculative write was not refused");

endmodule
`default_nettype wire

// ===== bench/cache_side_model.sv
// far-side model: write buffer, memory and cache answers
`default_nettype none
module cache_side_model (
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  input  wire logic i_slow,       // slow answers when high
  input  wire logic i_drain,      // drain request from the block
  input  wire logic i_flush,      // line writeback request
  input  wire logic i_inval,      // line invalidate request
  output logic      o_wbuf_empty,
  output logic      o_mem_idle,
  output logic      o_cache_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] dcnt; // cycles spent draining
  logic [1:0] ccnt; // cycles spent on the current line job
  logic [1:0] lat;  // answer delay in cycles
  assign lat = i_slow ? 2'h3 : 2'h0;
  // drain progress counter, held at the answer delay
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !i_drain) dcnt <= 2'h0;
    else if (dcnt != lat) dcnt <= dcnt + 2'h1;
  end
  // empty only inside a drain: new stores may land outside one
  assign o_wbuf_empty = i_drain && (dcnt == lat);
  assign o_mem_idle   = o_wbuf_empty;
  // one ack per line job, count restarts after each ack
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || o_cache_ack || !(i_flush || i_inval)) ccnt <= 2'h0;
    else ccnt <= ccnt + 2'h1;
  end
  assign o_cache_ack = (i_flush || i_inval) && (ccnt == lat);
endmodule
`default_nettype wire

// ===== bench/tb.sv
// self-checking bench for the memory-type cache policy block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic               clk = 1'b0;  // 20 MHz system clock
  logic               rst = 1'b1;  // synchronous reset
  logic               vld, spec, cdb, invalidate_without_writeback, dhit, lmod, ihit, slow;
  logic [1:0]         kind;        // access kind code
  logic [2:0]         pt, rt;      // page and range type codes
  wire logic          wbe, idle, ack;
  logic               rdy, rej, iss, drn, lwb, linv, stale;
  logic [12:0]        dec, got;    // decision bits, live and captured
  logic [2:0]         seen;        // drain, writeback, invalidate seen
  logic               grj;         // captured refusal
  mtp_pkg::mem_type_e eff, gef;    // effective type, live and captured
  int                 fail_count, total_checks;

  always #25 clk = ~clk;

  memory_type_cache_policy i_dut (
    .i_clk_sys(clk), .i_rst(rst), .i_req_valid(vld),
    .i_req_kind(mtp_pkg::access_kind_e'(kind)), .i_req_spec(spec),
    .i_page_type(mtp_pkg::mem_type_e'(pt)),
    .i_range_type(mtp_pkg::mem_type_e'(rt)),
    .i_cache_disable_control_bit(cdb), .i_invalidate_done(invalidate_without_writeback),
    .i_data_hit(dhit), .i_line_modified(lmod), .i_icache_hit(ihit),
    .i_wbuf_empty(wbe), .i_mem_idle(idle), .i_cache_ack(ack),
    .o_req_ready(rdy), .o_reject(rej), .o_issue(iss), .o_eff_type(eff),
    .o_cache_read(dec[12]), .o_allocate(dec[11]),
    .o_update_line(dec[10]), .o_set_modified(dec[9]),
    .o_drop_line(dec[8]), .o_icache_inv(dec[7]),
    .o_no_icache_replace(dec[6]), .o_mem_read(dec[5]),
    .o_mem_write(dec[4]), .o_combine(dec[3]), .o_use_wbuf(dec[2]),
    .o_snoop_all(dec[1]), .o_in_order(dec[0]), .o_drain_wbuf(drn),
    .o_line_writeback(lwb), .o_line_invalidate(linv), .o_cd_stale(stale)
  );

  cache_side_model i_far (
    .i_clk_sys(clk), .i_rst(rst), .i_slow(slow), .i_drain(drn),
    .i_flush(lwb), .i_inval(linv), .o_wbuf_empty(wbe),
    .o_mem_idle(idle), .o_cache_ack(ack)
  );

  // verdict and end of run, also reached on a hang
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // masked compare of captured bits
  task automatic chk(input string nm, input logic [12:0] e, m, g);
    total_checks++;
    if ((g & m) !== (e & m)) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e & m, g & m);
    end
  endtask

  // one request: wait idle, offer for one edge, await the answer
  task automatic go(input logic [1:0] k, input logic [2:0] p, r,
                    input logic s, h, md, ic);
    int n;
    n = 0;
    seen = 3'h0;
    while (rdy !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    // a ready that never comes is a hang as well
    if (rdy !== 1'b1) begin
      fail_count++;
      $display("MISMATCH ready expected 1 seen 0");
      wrap_up();
    end
    @(posedge clk);
    {kind, pt, rt} <= {k, p, r};
    {spec, dhit, lmod, ihit} <= {s, h, md, ic};
    vld <= 1'b1;
    @(posedge clk);
    vld <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      seen |= {drn, lwb, linv};
      n++;
    end while (!(iss === 1'b1 || rej === 1'b1) && n < 40);
    // a lost answer counts as a mismatch and ends the run
    if (iss !== 1'b1 && rej !== 1'b1) begin
      fail_count++;
      $display("MISMATCH answer expected 1 seen 0");
      wrap_up();
    end
    got = dec;
    gef = eff;
    grj = rej;
  endtask

  // writeback reads and writes
  task automatic t_wb();
    go(2'h0, 3'h6, 3'h6, 1'b1, 1'b0, 1'b0, 1'b0);
    chk("wb load", 13'h1820, 13'h1FFF, got);
    go(2'h1, 3'h6, 3'h6, 1'b0, 1'b1, 1'b0, 1'b0);
    chk("wb hit", 13'h0604, 13'h071C, got);
    go(2'h1, 3'h6, 3'h6, 1'b0, 1'b0, 1'b0, 1'b0);
    chk("wb miss", 13'h0A00, 13'h0A19, got);
  endtask

  // writethrough and write-protect
  task automatic t_wtwp();
    go(2'h1, 3'h4, 3'h4, 1'b0, 1'b1, 1'b0, 1'b0);
    chk("wt hit", 13'h0414, 13'h0F14, got);
    go(2'h1, 3'h4, 3'h4, 1'b0, 1'b0, 1'b0, 1'b0);
    chk("wt miss", 13'h0010, 13'h0C10, got);
    go(2'h0, 3'h4, 3'h4, 1'b1, 1'b0, 1'b0, 1'b0);
    chk("wt load", 13'h1800, 13'h1810, got);
    go(2'h1, 3'h5, 3'h5, 1'b0, 1'b1, 1'b0, 1'b0);
    chk("wp hit", 13'h0114, 13'h0714, got);
    go(2'h0, 3'h5, 3'h5, 1'b1, 1'b0, 1'b0, 1'b0);
    chk("wp load", 13'h1800, 13'h1810, got);
  endtask

  // combining types, kept off the ordinary write buffer
  task automatic t_comb();
    go(2'h1, 3'h1, 3'h1, 1'b0, 1'b0, 1'b0, 1'b0);
    chk("wc store", 13'h0018, 13'h1C1F, got);
    go(2'h1, 3'h2, 3'h2, 1'b0, 1'b0, 1'b0, 1'b0);
    chk("wcp store", 13'h001A, 13'h081A, got);
    go(2'h0, 3'h1, 3'h1, 1'b1, 1'b0, 1'b0, 1'b0);
    chk("wc load", 13'h0020, 13'h1820, got);
  endtask

  // uncacheable with prompt drain answers
  task automatic t_uc();
    slow <= 1'b0;
    go(2'h0, 3'h0, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    chk("uc load", 13'h0021, 13'h1829, got);
    chk("uc drain", 13'h0004, 13'h0004, {10'h000, seen});
    chk("uc ready", 13'h0001, 13'h0001, {12'h000, rdy});
    go(2'h1, 3'h0, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    chk("uc store", 13'h0011, 13'h081D, got);
  endtask

  // type conflict, slow cache answers
  task automatic t_cd();
    slow <= 1'b1;
    go(2'h1, 3'h6, 3'h4, 1'b0, 1'b1, 1'b1, 1'b1);
    chk("cd store", 13'h0091, 13'h0C99, got);
    chk("cd steps", 13'h0007, 13'h0007, {10'h000, seen});
    chk("cd type", 13'h0007, 13'h0007, {10'h000, gef});
    go(2'h0, 3'h6, 3'h4, 1'b0, 1'b1, 1'b0, 1'b0);
    chk("cd ld hit", 13'h0021, 13'h1821, got);
    chk("cd ld steps", 13'h0005, 13'h0007, {10'h000, seen});
    go(2'h2, 3'h6, 3'h4, 1'b0, 1'b0, 1'b0, 1'b0);
    chk("cd fmiss", 13'h0060, 13'h0860, got);
    go(2'h2, 3'h6, 3'h4, 1'b0, 1'b0, 1'b0, 1'b1);
    chk("cd fhit", 13'h1000, 13'h1020, got);
  endtask

  // disable bit before and after an invalidate
  task automatic t_dis();
    @(posedge clk);
    cdb <= 1'b1;
    repeat (3) @(posedge clk);
    chk("stale", 13'h0001, 13'h0001, {12'h000, stale});
    go(2'h0, 3'h6, 3'h6, 1'b0, 1'b0, 1'b0, 1'b0);
    chk("dis type", 13'h0007, 13'h0007, {10'h000, gef});
    chk("dis load", 13'h0021, 13'h1821, got);
    @(posedge clk);
    invalidate_without_writeback <= 1'b1;
    @(posedge clk);
    invalidate_without_writeback <= 1'b0;
    go(2'h0, 3'h6, 3'h6, 1'b0, 1'b0, 1'b0, 1'b0);
    chk("inv type", 13'h0000, 13'h0007, {10'h000, gef});
    @(posedge clk);
    cdb <= 1'b0;
  endtask

  // speculative requests that must be refused
  task automatic t_rej();
    go(2'h1, 3'h6, 3'h6, 1'b1, 1'b0, 1'b0, 1'b0);
    chk("spec st", 13'h0001, 13'h0001, {12'h000, grj});
    go(2'h0, 3'h0, 3'h0, 1'b1, 1'b0, 1'b0, 1'b0);
    chk("spec uc", 13'h0001, 13'h0001, {12'h000, grj});
    go(2'h0, 3'h6, 3'h5, 1'b1, 1'b0, 1'b0, 1'b0);
    chk("spec cd", 13'h0001, 13'h0001, {12'h000, grj});
  endtask

  // main sequence
  initial begin
    {vld, spec, cdb, invalidate_without_writeback, dhit, lmod, ihit, slow} = 8'h00;
    {kind, pt, rt} = 8'h00;
    fail_count = 0;
    total_checks = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_wb();
    t_wtwp();
    t_comb();
    t_uc();
    t_cd();
    t_dis();
    t_rej();
    wrap_up();
  end
endmodule
`default_nettype wire
